/* verilog/rsc_pkg.sv */
// Shared constants, types and register map of the reset source controller.
// Assumes the core clock is the high-frequency clock, so one fc period is one cycle.
`default_nettype none

package rsc_pkg;

    // One core clock per high-frequency clock period.
    localparam int CLK_PER_FC   = 1;

    // Times in high-frequency clock periods, and their cycle counts.
    localparam int MAL_LOW_FC   = 24;
    localparam int REL_DLY_FC   = 8;
    localparam int VEC_READ_FC  = 16;
    localparam int EXT_MIN_FC   = 12;
    localparam int MAL_LOW_CYC  = MAL_LOW_FC * CLK_PER_FC;
    localparam int REL_DLY_CYC  = REL_DLY_FC * CLK_PER_FC;
    localparam int VEC_READ_CYC = VEC_READ_FC * CLK_PER_FC;
    localparam int EXT_MIN_CYC  = EXT_MIN_FC * CLK_PER_FC;

    localparam int              CNT_W       = 5;
    localparam logic [CNT_W-1:0] MAL_LOW_LD = CNT_W'(MAL_LOW_CYC - 1);
    localparam logic [CNT_W-1:0] REL_LD     = CNT_W'(REL_DLY_CYC - 1);
    localparam logic [CNT_W-1:0] VEC_LD     = CNT_W'(VEC_READ_CYC - 1);
    localparam logic [CNT_W-1:0] VEC_HALF   = CNT_W'(VEC_READ_CYC / 2);
    localparam logic [CNT_W-1:0] EXT_LD     = CNT_W'(EXT_MIN_CYC - 1);

    // Reset vector and trap areas of the core address space.
    localparam logic [15:0] VEC_LO_ADDR = 16'hfffe;
    localparam logic [15:0] VEC_HI_ADDR = 16'hffff;
    localparam logic [15:0] SFR_LO      = 16'h0000;
    localparam logic [15:0] SFR_HI      = 16'h003f;
    localparam logic [15:0] RAM_LO      = 16'h0040;
    localparam logic [15:0] RAM_HI      = 16'h023f;
    localparam logic [15:0] DBR_LO      = 16'h0f80;
    localparam logic [15:0] DBR_HI      = 16'h0fff;

    // APB register map.
    localparam int          ADDR_W     = 8;
    localparam logic [7:0]  OFS_WDCTL  = 8'h00;
    localparam logic [7:0]  OFS_SYSCTL = 8'h04;
    localparam logic [7:0]  OFS_STAT   = 8'h08;
    localparam logic [7:0]  OFS_MASK   = 8'h0c;
    localparam logic [7:0]  OFS_STATE  = 8'h10;

    // Field positions.
    localparam int SYS_HF_BIT    = 7;
    localparam int SYS_LF_BIT    = 6;
    localparam int SYS_SEL_BIT   = 5;
    localparam int WD_W          = 4;
    localparam int EV_W          = 4;
    localparam int EV_TRAP       = 0;
    localparam int EV_WDOG       = 1;
    localparam int EV_CLKR       = 2;
    localparam int EV_EXTR       = 3;
    localparam int STATE_ST_LSB  = 0;
    localparam int STATE_RST_BIT = 2;
    localparam int STATE_PC_LSB  = 16;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_LOW  = 2'b01,
        ST_REL  = 2'b11,
        ST_VEC  = 2'b10
    } rsc_state_e;

    typedef struct packed {
        logic hf_en;
        logic lf_en;
        logic lf_sel;
    } rsc_sysctl_s;

    typedef struct packed {
        logic wdt_en;
        logic watchdog_action_select;
        logic trap_action_select;
        logic trap_ram_select;
    } rsc_wdctl_s;

    localparam rsc_sysctl_s SYSCTL_RST = '{hf_en: 1'b1, lf_en: 1'b0, lf_sel: 1'b0};
    localparam rsc_wdctl_s  WDCTL_RST  = '{wdt_en: 1'b1, watchdog_action_select: 1'b1,
                                           trap_action_select: 1'b1, trap_ram_select: 1'b0};

endpackage

`default_nettype wire

/* verilog/rsc_sync2.sv */
// Two-flip-flop synchroniser for one level from outside the clock domain.
// Assumes the input changes slowly against the clock.
`timescale 1ns/10ps
`default_nettype none

module rsc_sync2 #(
    parameter logic RST_VAL = 1'b1
) (
    input  wire logic i_clk,
    input  wire logic i_rst_n,
    input  wire logic i_d,
    output var  logic o_q
);
    logic meta_r;

    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            meta_r <= RST_VAL;
            o_q    <= RST_VAL;
        end else begin
            meta_r <= i_d;
            o_q    <= meta_r;
        end
    end
endmodule

`default_nettype wire

/* verilog/rsc_cnt.sv */
// Loadable down-counter that stops at zero.
// Assumes the load value fits the width.
`timescale 1ns/10ps
`default_nettype none

module rsc_cnt #(
    parameter int             W       = 5,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_load,
    input  wire logic [W-1:0] i_value,
    output var  logic [W-1:0] o_count,
    output logic              o_zero
);
    always_ff @(posedge i_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            o_count <= RST_VAL;
        end else if (i_load) begin
            o_count <= i_value;
        end else if (o_count != '0) begin
            o_count <= o_count - W'(1);
        end
    end

    assign o_zero = (o_count == '0);
endmodule

`default_nettype wire

/* verilog/rsc_top.sv */
// Reset source controller: merges pin, address trap, watchdog and clock resets.
// Assumes the vector memory answers one cycle after the address and the core runs on fc.
//
// Functional notes
// RL1: A malfunction reset drives the pin low and holds internal reset 24 cycles.
// RL2: After power-up one malfunction reset of 24 cycles may occur.
// RL3: The board holds the pin low at least 12 fc periods to apply reset.
// RL4: On pin release, leave reset and load the PC from the top vector.
// RL5: Reset clears master enable, enable flags and request latches.
// RL6: Reset clears prescaler and divider and leaves the watchdog enabled.
// RL7: Fetch from special function, data bank, or selected RAM raises a trap.
// RL8: After the low phase wait 8 cycles, then read the vector 16 cycles.
// RL9: Trap resets when trap action select is set, else raises the trap interrupt.
// RL10: Watchdog overflow resets when its select is set, else raises its interrupt.
// RL11: Illegal oscillator enable clears issue a system clock reset.
// RL12: A system clock reset leaves the oscillators running.
// RL13: Clock source select one picks the low-frequency clock, zero the high one.
// RL14: High-frequency enable bit starts and stops the high-frequency oscillator.
// RL15: Pin reset and malfunction requests merge into one internal reset.
`timescale 1ns/10ps
`default_nettype none

module rsc_top (
    input  wire logic                      I_CORE_CLK,
    input  wire logic                      I_RESET_N,
    input  wire logic                      I_PSEL,
    input  wire logic                      I_PENABLE,
    input  wire logic                      I_PWRITE,
    input  wire logic [rsc_pkg::ADDR_W-1:0] I_PADDR,
    input  wire logic [31:0]               I_PWDATA,
    output var  logic [31:0]               O_PRDATA,
    output logic                           O_PREADY,
    output logic                           O_PSLVERR,
    input  wire logic                      I_RESET_PIN_I,
    output logic                           O_RESET_PIN_O,
    output logic                           O_RESET_PIN_OE,
    input  wire logic                      I_FETCH_VALID,
    input  wire logic [15:0]               I_FETCH_ADDR,
    input  wire logic                      I_WDT_OVF,
    output logic                           O_VEC_RD,
    output logic [15:0]                    O_VEC_ADDR,
    input  wire logic [7:0]                I_VEC_DATA,
    output var  logic [15:0]               O_PC,
    output var  logic                      O_PC_LOAD,
    output logic                           O_CORE_RESET,
    output logic                           O_CORE_HOLD,
    output logic                           O_INT_FLAGS_CLR,
    output logic                           O_PRESCALER_CLR,
    output logic                           O_WDT_EN,
    output var  logic                      O_TRAP_INT,
    output var  logic                      O_WDT_INT,
    output logic                           O_HF_OSC_EN,
    output logic                           O_LF_OSC_EN,
    output logic                           O_CLK_SEL_LF,
    output logic                           O_IRQ
);

    rsc_pkg::rsc_state_e        state_r;
    rsc_pkg::rsc_state_e        state_nxt;
    rsc_pkg::rsc_sysctl_s       sys_r;
    rsc_pkg::rsc_sysctl_s       sys_wr;
    rsc_pkg::rsc_wdctl_s        wd_r;
    logic [rsc_pkg::CNT_W-1:0]  tmr_cnt;
    logic [rsc_pkg::CNT_W-1:0]  tmr_val;
    logic [rsc_pkg::CNT_W-1:0]  ext_cnt;
    logic                       tmr_zero;
    logic                       tmr_load;
    logic                       ext_zero;
    logic                       pin_s;
    logic                       ext_act;
    logic                       ext_act_r;
    logic                       int_rst_r;
    logic                       trap_hit;
    logic                       clk_rst;
    logic                       mal_req;
    logic                       apb_acc;
    logic                       apb_hit;
    logic                       wr_sys;
    logic                       wr_wd;
    logic [rsc_pkg::EV_W-1:0]   ev;
    logic [rsc_pkg::EV_W-1:0]   stat_r;
    logic [rsc_pkg::EV_W-1:0]   mask_r;
    logic [7:0]                 vec_lo_r;
    logic [31:0]                rd_nxt;

    default clocking cb @(posedge I_CORE_CLK);
    endclocking
    default disable iff (!I_RESET_N);

    // Reset pin readback passes a synchroniser before any logic sees it.
    rsc_sync2 #(
        .RST_VAL (1'b1)
    ) u_pin_sync (
        .i_clk   (I_CORE_CLK),
        .i_rst_n (I_RESET_N),
        .i_d     (I_RESET_PIN_I),
        .o_q     (pin_s)
    );

    // Phase timer; it starts in the low phase because the malfunction logic has
    // no power-on clear.
    rsc_cnt #(
        .W       (rsc_pkg::CNT_W),
        .RST_VAL (rsc_pkg::MAL_LOW_LD)
    ) u_phase_tmr (
        .i_clk   (I_CORE_CLK),
        .i_rst_n (I_RESET_N),
        .i_load  (tmr_load),
        .i_value (tmr_val),
        .o_count (tmr_cnt),
        .o_zero  (tmr_zero)
    );

    // Counts how long the board has held the pin low while this block is not
    // driving it; our own released low phase never lasts long enough to count.
    rsc_cnt #(
        .W       (rsc_pkg::CNT_W),
        .RST_VAL (rsc_pkg::EXT_LD)
    ) u_ext_filt (
        .i_clk   (I_CORE_CLK),
        .i_rst_n (I_RESET_N),
        .i_load  (pin_s || O_RESET_PIN_OE),
        .i_value (rsc_pkg::EXT_LD),
        .o_count (ext_cnt),
        .o_zero  (ext_zero)
    );

    assign ext_act = !pin_s && !O_RESET_PIN_OE && ext_zero;  // see RL3

    // Address trap detection on instruction fetch.
    always_comb begin
        trap_hit = 1'b0;
        if (I_FETCH_VALID && state_r == rsc_pkg::ST_IDLE) begin
            trap_hit = (I_FETCH_ADDR >= rsc_pkg::SFR_LO && I_FETCH_ADDR <= rsc_pkg::SFR_HI)
                    || (I_FETCH_ADDR >= rsc_pkg::DBR_LO && I_FETCH_ADDR <= rsc_pkg::DBR_HI)
                    || (wd_r.trap_ram_select && I_FETCH_ADDR >= rsc_pkg::RAM_LO
                        && I_FETCH_ADDR <= rsc_pkg::RAM_HI);  // see RL7
        end
    end

    // APB decode; one setup cycle, then a zero-wait access phase.
    assign apb_acc   = I_PSEL && I_PENABLE;
    assign apb_hit   = I_PADDR == rsc_pkg::OFS_WDCTL || I_PADDR == rsc_pkg::OFS_SYSCTL
                    || I_PADDR == rsc_pkg::OFS_STAT || I_PADDR == rsc_pkg::OFS_MASK
                    || I_PADDR == rsc_pkg::OFS_STATE;
    assign O_PREADY  = apb_acc;
    assign O_PSLVERR = apb_acc && !apb_hit;
    assign wr_sys    = apb_acc && I_PWRITE && I_PADDR == rsc_pkg::OFS_SYSCTL;
    assign wr_wd     = apb_acc && I_PWRITE && I_PADDR == rsc_pkg::OFS_WDCTL;

    assign sys_wr.hf_en  = I_PWDATA[rsc_pkg::SYS_HF_BIT];
    assign sys_wr.lf_en  = I_PWDATA[rsc_pkg::SYS_LF_BIT];
    assign sys_wr.lf_sel = I_PWDATA[rsc_pkg::SYS_SEL_BIT];

    // A write that clears the enable of the currently selected oscillator, or clears both enables, is turned into a reset.
    assign clk_rst = wr_sys && (
           (sys_r.hf_en && sys_r.lf_en && !sys_wr.hf_en && !sys_wr.lf_en)
        || (sys_r.hf_en && !sys_wr.hf_en && !sys_r.lf_sel)
        || (sys_r.lf_en && !sys_wr.lf_en && sys_r.lf_sel));  // see RL11

    assign mal_req = (trap_hit && wd_r.trap_action_select)              // see RL9
                  || (I_WDT_OVF && wd_r.watchdog_action_select)         // see RL10
                  || clk_rst;

    // Reset phase sequence: low phase, release delay, vector read.
    always_comb begin
        state_nxt = state_r;
        tmr_load  = 1'b0;
        tmr_val   = rsc_pkg::MAL_LOW_LD;
        if (ext_act) begin
            state_nxt = rsc_pkg::ST_REL;  // see RL4
            tmr_load  = 1'b1;
            tmr_val   = rsc_pkg::REL_LD;
        end else if (mal_req && state_r != rsc_pkg::ST_LOW) begin
            state_nxt = rsc_pkg::ST_LOW;  // see RL1
            tmr_load  = 1'b1;
        end else if (tmr_zero) begin
            unique case (state_r)
                rsc_pkg::ST_IDLE: begin
                    state_nxt = rsc_pkg::ST_IDLE;
                end
                rsc_pkg::ST_LOW: begin
                    state_nxt = rsc_pkg::ST_REL;  // see RL8
                    tmr_load  = 1'b1;
                    tmr_val   = rsc_pkg::REL_LD;
                end
                rsc_pkg::ST_REL: begin
                    state_nxt = rsc_pkg::ST_VEC;  // see RL8
                    tmr_load  = 1'b1;
                    tmr_val   = rsc_pkg::VEC_LD;
                end
                rsc_pkg::ST_VEC: begin
                    state_nxt = rsc_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            state_r <= rsc_pkg::ST_LOW;  // see RL2
        end else begin
            state_r <= state_nxt;
        end
    end

    // Internal reset covers the low phase and a pin reset alike.
    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            int_rst_r <= 1'b1;
            ext_act_r <= 1'b0;
        end else begin
            int_rst_r <= (state_nxt == rsc_pkg::ST_LOW) || ext_act;  // see RL15
            ext_act_r <= ext_act;
        end
    end

    assign O_RESET_PIN_O   = 1'b0;
    assign O_RESET_PIN_OE  = (state_r == rsc_pkg::ST_LOW);  // see RL1
    assign O_CORE_RESET    = int_rst_r;
    assign O_CORE_HOLD     = (state_r != rsc_pkg::ST_IDLE) || int_rst_r;
    assign O_INT_FLAGS_CLR = int_rst_r;  // see RL5
    assign O_PRESCALER_CLR = int_rst_r;  // see RL6

    // Vector read: low byte for the first half, high byte for the second.
    assign O_VEC_RD   = (state_r == rsc_pkg::ST_VEC);
    assign O_VEC_ADDR = (tmr_cnt >= rsc_pkg::VEC_HALF) ? rsc_pkg::VEC_LO_ADDR
                                                       : rsc_pkg::VEC_HI_ADDR;

    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            vec_lo_r  <= 8'h00;
            O_PC      <= 16'h0000;
            O_PC_LOAD <= 1'b0;
        end else begin
            O_PC_LOAD <= 1'b0;
            if (state_r == rsc_pkg::ST_VEC && tmr_cnt == rsc_pkg::VEC_HALF) begin
                vec_lo_r <= I_VEC_DATA;
            end
            if (state_r == rsc_pkg::ST_VEC && state_nxt == rsc_pkg::ST_IDLE) begin
                O_PC      <= {I_VEC_DATA, vec_lo_r};  // see RL4
                O_PC_LOAD <= 1'b1;
            end
        end
    end

    // Non-maskable interrupt requests when the action selects ask for them.
    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_TRAP_INT <= 1'b0;
            O_WDT_INT  <= 1'b0;
        end else begin
            O_TRAP_INT <= trap_hit && !wd_r.trap_action_select;  // see RL9
            O_WDT_INT  <= I_WDT_OVF && !wd_r.watchdog_action_select;  // see RL10
        end
    end

    // Watchdog control; reset restores reset action and an enabled watchdog.
    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            wd_r <= rsc_pkg::WDCTL_RST;
        end else if (int_rst_r) begin
            wd_r <= rsc_pkg::WDCTL_RST;  // see RL6
        end else if (wr_wd) begin
            wd_r <= rsc_pkg::rsc_wdctl_s'(I_PWDATA[rsc_pkg::WD_W-1:0]);
        end
    end

    // System clock control; a refused write is dropped, and the reset it causes sets the high-frequency enable, clears the select and keeps the low one.
    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            sys_r <= rsc_pkg::SYSCTL_RST;
        end else if (int_rst_r) begin
            sys_r.hf_en  <= rsc_pkg::SYSCTL_RST.hf_en;
            sys_r.lf_sel <= rsc_pkg::SYSCTL_RST.lf_sel;
        end else if (wr_sys && !clk_rst) begin
            sys_r <= sys_wr;  // see RL12
        end
    end

    assign O_HF_OSC_EN  = sys_r.hf_en;   // see RL14
    assign O_LF_OSC_EN  = sys_r.lf_en;
    assign O_CLK_SEL_LF = sys_r.lf_sel;  // see RL13
    assign O_WDT_EN     = wd_r.wdt_en;

    // Sticky cause flags; a new event wins over a write-one clear.
    always_comb begin
        ev                   = '0;
        ev[rsc_pkg::EV_TRAP] = trap_hit;
        ev[rsc_pkg::EV_WDOG] = I_WDT_OVF;
        ev[rsc_pkg::EV_CLKR] = clk_rst;
        ev[rsc_pkg::EV_EXTR] = ext_act && !ext_act_r;
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            stat_r <= '0;
            mask_r <= '0;
        end else begin
            if (apb_acc && I_PWRITE && I_PADDR == rsc_pkg::OFS_STAT) begin
                stat_r <= (stat_r & ~I_PWDATA[rsc_pkg::EV_W-1:0]) | ev;
            end else begin
                stat_r <= stat_r | ev;
            end
            if (apb_acc && I_PWRITE && I_PADDR == rsc_pkg::OFS_MASK) begin
                mask_r <= I_PWDATA[rsc_pkg::EV_W-1:0];
            end
        end
    end

    assign O_IRQ = |(stat_r & mask_r);

    // Read data is captured in the setup cycle.
    always_comb begin
        rd_nxt = 32'h0000_0000;
        unique case (I_PADDR)
            rsc_pkg::OFS_WDCTL: rd_nxt[rsc_pkg::WD_W-1:0] = wd_r;
            rsc_pkg::OFS_SYSCTL: begin
                rd_nxt[rsc_pkg::SYS_HF_BIT]  = sys_r.hf_en;
                rd_nxt[rsc_pkg::SYS_LF_BIT]  = sys_r.lf_en;
                rd_nxt[rsc_pkg::SYS_SEL_BIT] = sys_r.lf_sel;
            end
            rsc_pkg::OFS_STAT: rd_nxt[rsc_pkg::EV_W-1:0] = stat_r;
            rsc_pkg::OFS_MASK: rd_nxt[rsc_pkg::EV_W-1:0] = mask_r;
            rsc_pkg::OFS_STATE: begin
                rd_nxt[rsc_pkg::STATE_ST_LSB +: 2]  = state_r;
                rd_nxt[rsc_pkg::STATE_RST_BIT]      = int_rst_r;
                rd_nxt[rsc_pkg::STATE_PC_LSB +: 16] = O_PC;
            end
            default: rd_nxt = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            O_PRDATA <= 32'h0000_0000;
        end else if (I_PSEL && !I_PENABLE) begin
            O_PRDATA <= rd_nxt;
        end
    end

    // Checks.
    logic [5:0] low_run_r;

    always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
        if (!I_RESET_N) begin
            low_run_r <= 6'h00;
        end else if (state_r == rsc_pkg::ST_LOW) begin
            low_run_r <= low_run_r + 6'h01;
        end else begin
            low_run_r <= 6'h00;
        end
    end

    a_low_max_len: assert property ( // see RL1
        low_run_r <= 6'(rsc_pkg::MAL_LOW_CYC))
        else $error("Malfunction low phase ran past its limit.");

    a_mal_enter_low: assert property ( // see RL1
        mal_req && !ext_act && state_r != rsc_pkg::ST_LOW
        |=> O_RESET_PIN_OE && O_CORE_RESET)
        else $error("Malfunction request did not start a driven reset.");

    a_rel_delay_len: assert property ( // see RL8
        $rose(state_r == rsc_pkg::ST_VEC) |-> $past(state_r, 8) == rsc_pkg::ST_REL)
        else $error("Release delay before vector read is wrong.");

    a_vec_read_len: assert property ( // see RL8
        O_PC_LOAD |-> $past(O_VEC_RD, 16) && !$past(O_VEC_RD, 17))
        else $error("Vector read did not last sixteen cycles.");

    a_pc_from_vec: assert property ( // see RL4
        O_PC_LOAD |-> O_PC[15:8] == $past(I_VEC_DATA) && $past(O_VEC_ADDR) == rsc_pkg::VEC_HI_ADDR)
        else $error("Program counter not loaded from the high vector byte.");

    a_trap_to_int: assert property ( // see RL9
        trap_hit && !wd_r.trap_action_select && !mal_req |=> O_TRAP_INT && !O_RESET_PIN_OE)
        else $error("Trap in interrupt mode did not raise the trap interrupt.");

    a_wdt_to_int: assert property ( // see RL10
        I_WDT_OVF && !wd_r.watchdog_action_select && !mal_req && !ext_act
        |=> O_WDT_INT && !$rose(O_RESET_PIN_OE))
        else $error("Watchdog in interrupt mode did not raise its interrupt.");

    a_clk_rst_osc: assert property ( // see RL12
        clk_rst |=> $stable(O_HF_OSC_EN) && $stable(O_LF_OSC_EN) ##1 O_CORE_RESET)
        else $error("System clock reset stopped an oscillator.");

    a_reset_init: assert property ( // see RL6
        O_CORE_RESET ##1 !O_CORE_RESET |-> O_WDT_EN && wd_r.trap_action_select)
        else $error("Reset did not restore the watchdog control.");

    a_ext_merge: assert property ( // see RL15
        ext_act |=> O_CORE_RESET && state_r == rsc_pkg::ST_REL)
        else $error("Pin reset did not assert the internal reset.");

endmodule

`default_nettype wire

/* verif/rsc_board_model.sv */
// Board reset supervisor that pulls the open-drain reset pin low on request.
// Assumes a pull-up on the pin and a bench that sets how long it pulls.
`timescale 1ns/10ps
`default_nettype none
module rsc_board_model (
    input  wire logic i_clk,
    input  wire logic i_pull_req,
    input  wire logic i_dut_oe,
    input  wire logic i_dut_o,
    output logic      o_pin
);
    logic pull_r = 1'b0;
    always_ff @(posedge i_clk) begin
        pull_r <= i_pull_req;
    end
    assign o_pin = (i_dut_oe ? i_dut_o : 1'b1) & ~pull_r;
endmodule
`default_nettype wire

/* verif/tb_rsc_top.sv */
// Self-checking bench of the reset source controller with a board model.
// Assumes zero-wait APB answers and a vector memory one cycle behind its address.
`timescale 1ns/10ps
`default_nettype none
module tb_rsc_top;
    logic        clk = 1'b0, rst_n = 1'b0, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic        fv = 1'b0, wovf = 1'b0, pull = 1'b0, err, pready, pslverr, pin, pin_o;
    logic        oe, vrd, hold, pcl, crst, ifc, psc, wden, tint, wint, hf, lf, sel, irq;
    logic [7:0]  paddr = 8'h00, vdata = 8'h00, vlo, vhi;
    logic [15:0] fa = 16'h0000, vaddr, pc;
    logic [31:0] pwdata = 32'h0, rd, prdata;
    int          seed = 32'h3303, n_errors = 0, n_checks = 0, noe, ncr, nhd, nvr, cyc = 0;
    always #4 clk = ~clk;
    rsc_top u_dut (.I_CORE_CLK(clk), .I_RESET_N(rst_n), .I_PSEL(psel), .I_PENABLE(pen),
        .I_PWRITE(pwr), .I_PADDR(paddr), .I_PWDATA(pwdata), .O_PRDATA(prdata),
        .O_PREADY(pready), .O_PSLVERR(pslverr), .I_RESET_PIN_I(pin), .O_RESET_PIN_O(pin_o),
        .O_RESET_PIN_OE(oe), .I_FETCH_VALID(fv), .I_FETCH_ADDR(fa), .I_WDT_OVF(wovf),
        .O_VEC_RD(vrd), .O_VEC_ADDR(vaddr), .I_VEC_DATA(vdata), .O_PC(pc), .O_PC_LOAD(pcl),
        .O_CORE_RESET(crst), .O_CORE_HOLD(hold), .O_INT_FLAGS_CLR(ifc), .O_PRESCALER_CLR(psc),
        .O_WDT_EN(wden), .O_TRAP_INT(tint), .O_WDT_INT(wint), .O_HF_OSC_EN(hf),
        .O_LF_OSC_EN(lf), .O_CLK_SEL_LF(sel), .O_IRQ(irq));
    rsc_board_model u_board (.i_clk(clk), .i_pull_req(pull), .i_dut_oe(oe), .i_dut_o(pin_o),
        .o_pin(pin));
    always @(posedge clk) vdata <= vaddr[0] ? vhi : vlo;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 6000) begin
            n_errors++;
            print_verdict;
        end
    end
    task automatic print_verdict;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        pen <= 1'b0;
    endtask
    task automatic event_pulse(input logic w, input logic [15:0] a);
        @(posedge clk);
        fv <= ~w;
        wovf <= w;
        fa <= a;
        @(posedge clk);
        fv <= 1'b0;
        wovf <= 1'b0;
    endtask
    task automatic cnt(input int pl);
        noe = 0;
        ncr = 0;
        nhd = 0;
        nvr = 0;
        for (int j = 0; j < 40; j++) begin
            @(posedge clk);
            pull <= (j < pl);
            noe += (oe === 1'b1);
            ncr += (crst === 1'b1);
            nhd += (hold === 1'b1);
            nvr += (vrd === 1'b1);
        end
    endtask
    task automatic wpl;
        while (pcl !== 1'b1) @(posedge clk);
        chk({16'h0, pc}, {16'h0, vhi, vlo});
    endtask
    function automatic logic [15:0] area(input int i, input logic [15:0] r);
        case (i)
            0: return rsc_pkg::SFR_LO + (r & 16'h003f);
            1: return rsc_pkg::DBR_LO + (r & 16'h007f);
            default: return rsc_pkg::RAM_LO + (r & 16'h01ff);
        endcase
    endfunction
    initial begin
        vlo = 8'($random(seed));
        vhi = 8'($random(seed));
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        wpl;
        @(posedge clk);
        chk({28'h0, crst, ifc, psc, wden}, 32'h1);
        apb(1'b0, rsc_pkg::OFS_WDCTL, 32'h0);
        chk(rd, 32'he);
        apb(1'b0, rsc_pkg::OFS_SYSCTL, 32'h0);
        chk(rd, 32'h80);
        apb(1'b0, 8'h14, 32'h0);
        chk({31'h0, err}, 32'h1);
        $display("power-on tests done");
        for (int i = 0; i < 5; i++) begin
            apb(1'b1, rsc_pkg::OFS_WDCTL, (i == 3) ? 32'he : 32'hf);
            event_pulse(i == 4, area(i, 16'($random(seed))));
            cnt(0);
            chk(noe, (i == 3) ? 0 : 24);
            chk(ncr, (i == 3) ? 0 : 24);
            chk(nhd, (i == 3) ? 0 : 40);
            chk(nvr, (i == 3) ? 0 : 40 - rsc_pkg::MAL_LOW_CYC - rsc_pkg::REL_DLY_CYC);
            if (i != 3) wpl;
        end
        $display("malfunction reset tests done");
        apb(1'b1, rsc_pkg::OFS_STAT, 32'hf);
        apb(1'b1, rsc_pkg::OFS_MASK, 32'h3);
        apb(1'b1, rsc_pkg::OFS_WDCTL, 32'h8);
        for (int i = 0; i < 2; i++) begin
            event_pulse(i == 1, area(0, 16'h0005));
            @(posedge clk);
            chk({30'h0, wint, tint}, i ? 32'h2 : 32'h1);
        end
        cnt(0);
        chk({noe[30:0], irq}, 32'h1);
        apb(1'b1, rsc_pkg::OFS_MASK, 32'h0);
        @(posedge clk);
        chk({31'h0, irq}, 32'h0);
        $display("interrupt tests done");
        for (int k = 0; k < 2; k++) begin
            if (k == 1) begin
                apb(1'b1, rsc_pkg::OFS_SYSCTL, 32'he0);
                apb(1'b1, rsc_pkg::OFS_SYSCTL, 32'h60);
                @(posedge clk);
                chk({31'h0, hf}, 32'h0);
            end
            chk({31'h0, sel}, k);
            apb(1'b1, rsc_pkg::OFS_SYSCTL, k ? 32'h80 : 32'h0);
            cnt(0);
            chk({noe[29:0], lf, hf}, k ? 32'h63 : 32'h61);
            wpl;
        end
        $display("clock reset tests done");
        for (int k = 0; k < 2; k++) begin
            cnt(k ? 30 : 8);
            chk({noe[30:0], ncr != 0}, k);
            if (k == 1) wpl;
        end
        $display("pin reset tests done");
        print_verdict;
    end
endmodule
`default_nettype wire
